// >>> inc/irec_pkg.sv
/*
  Shared constants, state codes and carriers for the rail enable control
  target port. Assumes a single 100 MHz system clock and that the serial
  clock and data arrive as raw, asynchronous pin levels.
*/
package irec_pkg;

  localparam int          ADDR_W        = 11;
  localparam int          BLK_W         = 3;
  localparam int          CNT_W         = 4;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // Byte address of the rail byte and the position of its two controls
  localparam logic [10:0] RAIL_BYTE     = 11'h0F4;
  localparam int          IO_RAIL_BIT   = 5;
  localparam int          MAIN_RAIL_BIT = 6;
  localparam logic [7:0]  RAIL_RST      = 8'h00;

  // Control code nibble lives in the low half of this byte
  localparam logic [10:0] CODE_BYTE     = 11'h0E9;
  localparam int          CODE_LSB      = 0;
  localparam logic [7:0]  CODE_BYTE_RST = 8'h06;

  // Lockable region covers bytes below this limit
  localparam logic [10:0] LOCK_LIMIT    = 11'h0C0;
  localparam logic [7:0]  LOCKED_RD     = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b011,
    ST_TX   = 3'b010,
    ST_MACK = 3'b110
  } irec_state_t;

  typedef enum logic [1:0] {
    PH_CTRL = 2'b00,
    PH_WORD = 2'b01,
    PH_DATA = 2'b11
  } irec_phase_t;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } irec_wr_t;

  typedef struct packed {
    logic rd_low;
    logic wr_low;
    logic wr_all;
  } irec_lock_t;

  function automatic logic locked_low(input logic [ADDR_W-1:0] a);
    return a < LOCK_LIMIT;
  endfunction : locked_low

endpackage : irec_pkg

// >>> hdl/irec_pin_sync.sv
/*
  Two-flop synchronisers with edge detection for asynchronous pins.
  Assumes one free-running clock; edges are seen from the second and
  third stages only.
*/
`timescale 1ns/10ps
module irec_pin_sync #(
  parameter int N = 2
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] s3;

  // Idle bus is high, so stages reset high to avoid a false start
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1[g] <= 1'b1;
          s2[g] <= 1'b1;
          s3[g] <= 1'b1;
        end else begin
          s1[g] <= pin_in[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
        end
      end
      assign level[g] = s2[g];
      assign rise[g]  = s2[g] & ~s3[g];
      assign fall[g]  = ~s2[g] & s3[g];
    end
  endgenerate

endmodule : irec_pin_sync

// >>> hdl/irec_cfg_mem.sv
/*
  Byte-addressed configuration space with lock gating. The control code
  and rail bytes are reset registers; the rest is plain storage with no
  defined content after power-up. Assumes one write per clock at most.
*/
`timescale 1ns/10ps
module irec_cfg_mem (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire irec_pkg::irec_wr_t          wr,
  input  wire irec_pkg::irec_lock_t        lock,
  input  wire logic [irec_pkg::ADDR_W-1:0] rd_addr,
  output logic      [7:0]                  rd_data,
  output logic      [3:0]                  code,
  output logic      [7:0]                  rail
);

  logic [7:0] mem [2**irec_pkg::ADDR_W];
  logic [7:0] code_byte;
  logic [7:0] next_code_byte;
  logic [7:0] next_rail;
  logic       wr_ok;

  always_comb begin
    wr_ok = wr.en & ~lock.wr_all &
            ~(lock.wr_low & irec_pkg::locked_low(wr.addr)); // [R14]
    next_code_byte = code_byte;
    next_rail      = rail;
    if (wr_ok && wr.addr == irec_pkg::CODE_BYTE) begin
      next_code_byte = wr.data; // [R1]
    end
    if (wr_ok && wr.addr == irec_pkg::RAIL_BYTE) begin
      next_rail = wr.data; // [R11] [R12] [R16]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      code_byte <= irec_pkg::CODE_BYTE_RST;
      rail      <= irec_pkg::RAIL_RST;
    end else begin
      code_byte <= next_code_byte;
      rail      <= next_rail;
    end
  end

  // Storage is data, not control state, so it carries no reset
  always_ff @(posedge clk) begin
    if (wr_ok) begin
      mem[wr.addr] <= wr.data; // [R7]
    end
  end

  always_comb begin
    if (lock.rd_low && irec_pkg::locked_low(rd_addr)) begin
      rd_data = irec_pkg::LOCKED_RD; // [R14]
    end else if (rd_addr == irec_pkg::CODE_BYTE) begin
      rd_data = code_byte;
    end else if (rd_addr == irec_pkg::RAIL_BYTE) begin
      rd_data = rail;
    end else begin
      rd_data = mem[rd_addr];
    end
  end

  assign code = code_byte[irec_pkg::CODE_LSB +: 4];

endmodule : irec_cfg_mem

// >>> hdl/irec_target.sv
/*
  Serial target port that reaches the configuration space and drives the
  two rail enable pins. Assumes raw serial clock and data pins, an open
  drain data wire resolved outside, and a system clock far above the bus
  clock so every bus edge is seen by sampling.
*/
// How it works
// R1 - Control code nibble must match programmed field
// R2 - Block bits form top address bits
// R3 - Last control bit: zero writes, one reads
// R4 - Acknowledge a matching control byte, ninth clock
// R5 - Word address follows control byte, sets pointer
// R6 - Byte write: control, word, data, stop; ack each
// R7 - Write data commits when its acknowledge starts
// R8 - Repeated start abandons write, keeps loaded address
// R9 - Read control byte acknowledged, eight bits shifted out
// R10 - Answers target address 0x30 after reset
// R11 - Byte 0xF4 bit 5 drives IO rail
// R12 - Byte 0xF4 bit 6 drives main rail
// R13 - Master changes rails by writing word 0xF4
// R14 - Lock inputs block reads or writes
// R15 - Current address read; pointer advances per byte
// R16 - Bit n sits in byte n/8, bit n%8
`timescale 1ns/10ps
module irec_target (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  input  wire irec_pkg::irec_lock_t lock,
  output logic                      io_rail_enable_out,
  output logic                      main_rail_enable_out
);

  irec_pkg::irec_state_t           state;
  irec_pkg::irec_state_t           next_state;
  irec_pkg::irec_phase_t           phase;
  irec_pkg::irec_phase_t           next_phase;
  logic [irec_pkg::CNT_W-1:0]      cnt;
  logic [irec_pkg::CNT_W-1:0]      next_cnt;
  logic [7:0]                      rx;
  logic [7:0]                      next_rx;
  logic [7:0]                      tx;
  logic [7:0]                      next_tx;
  logic [irec_pkg::ADDR_W-1:0]     ptr;
  logic [irec_pkg::ADDR_W-1:0]     next_ptr;
  logic [irec_pkg::BLK_W-1:0]      blk;
  logic [irec_pkg::BLK_W-1:0]      next_blk;
  logic                            dir;
  logic                            next_dir;
  logic                            mack;
  logic                            next_mack;
  logic                            next_sda_oe;
  irec_pkg::irec_wr_t              wr;
  logic [7:0]                      rd_data;
  logic [3:0]                      code;
  logic [7:0]                      rail;
  logic [1:0]                      lvl;
  logic [1:0]                      rise;
  logic [1:0]                      fall;
  logic                            scl_rise;
  logic                            scl_fall;
  logic                            start;
  logic                            stop;
  logic                            byte_end;

  irec_pin_sync #(
    .N (2)
  ) u_sync (
    .clk    (clk),
    .rstn   (rstn),
    .pin_in ({scl_in, sda_in}),
    .level  (lvl),
    .rise   (rise),
    .fall   (fall)
  );

  irec_cfg_mem u_mem (
    .clk     (clk),
    .rstn    (rstn),
    .wr      (wr),
    .lock    (lock),
    .rd_addr (ptr),
    .rd_data (rd_data),
    .code    (code),
    .rail    (rail)
  );

  assign scl_rise = rise[1];
  assign scl_fall = fall[1];
  // Data edges while the clock is high frame a transfer
  assign start    = fall[0] & lvl[1];
  assign stop     = rise[0] & lvl[1];
  assign byte_end = scl_fall & (cnt == irec_pkg::BITS_PER_BYTE);

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_cnt   = cnt;
    next_rx    = rx;
    next_tx    = tx;
    next_ptr   = ptr;
    next_blk   = blk;
    next_dir   = dir;
    next_mack  = mack;
    wr         = '0;
    if (start) begin
      next_state = irec_pkg::ST_RX; // [R8]
      next_phase = irec_pkg::PH_CTRL;
      next_cnt   = '0;
    end else if (stop) begin
      next_state = irec_pkg::ST_IDLE; // [R6]
    end else begin
      unique case (state)
        irec_pkg::ST_IDLE: begin
        end
        irec_pkg::ST_RX: begin
          if (scl_rise) begin
            next_rx  = {rx[6:0], lvl[0]};
            next_cnt = cnt + 4'd1;
          end else if (byte_end) begin
            next_cnt = '0;
            unique case (phase)
              irec_pkg::PH_CTRL: begin
                if (rx[7:4] == code) begin
                  next_state = irec_pkg::ST_ACK; // [R1] [R4] [R10]
                  next_blk   = rx[3:1]; // [R2]
                  next_dir   = rx[0]; // [R3]
                end else begin
                  next_state = irec_pkg::ST_IDLE; // [R1]
                end
              end
              irec_pkg::PH_WORD: begin
                next_state = irec_pkg::ST_ACK; // [R6]
                next_ptr   = {blk, rx}; // [R2] [R5] [R16]
              end
              irec_pkg::PH_DATA: begin
                next_state = irec_pkg::ST_ACK; // [R6]
                wr.en      = 1'b1; // [R7] [R13]
                wr.addr    = ptr;
                wr.data    = rx;
                next_ptr   = ptr + 11'd1; // [R15]
              end
              default: begin
                next_state = irec_pkg::ST_IDLE;
              end
            endcase
          end
        end
        irec_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (phase == irec_pkg::PH_CTRL && dir) begin
              next_state = irec_pkg::ST_TX; // [R9] [R15]
              next_tx    = rd_data;
              next_ptr   = ptr + 11'd1; // [R15]
            end else begin
              next_state = irec_pkg::ST_RX; // [R5]
              next_phase = (phase == irec_pkg::PH_CTRL) ?
                           irec_pkg::PH_WORD : irec_pkg::PH_DATA;
            end
          end
        end
        irec_pkg::ST_TX: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'd1;
          end else if (byte_end) begin
            next_state = irec_pkg::ST_MACK; // [R9]
            next_cnt   = '0;
          end else if (scl_fall) begin
            next_tx = {tx[6:0], 1'b1};
          end
        end
        irec_pkg::ST_MACK: begin
          if (scl_rise) begin
            next_mack = ~lvl[0];
          end else if (scl_fall) begin
            if (mack) begin
              next_state = irec_pkg::ST_TX; // [R15]
              next_tx    = rd_data;
              next_ptr   = ptr + 11'd1;
            end else begin
              next_state = irec_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          next_state = irec_pkg::ST_IDLE;
        end
      endcase
    end
    // Only ever pull low; a one bit is the wire released
    next_sda_oe = (next_state == irec_pkg::ST_ACK) |
                  ((next_state == irec_pkg::ST_TX) & ~next_tx[7]); // [R4]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state  <= irec_pkg::ST_IDLE;
      phase  <= irec_pkg::PH_CTRL;
      cnt    <= '0;
      rx     <= '0;
      tx     <= '0;
      ptr    <= '0;
      blk    <= '0;
      dir    <= 1'b0;
      mack   <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      state  <= next_state;
      phase  <= next_phase;
      cnt    <= next_cnt;
      rx     <= next_rx;
      tx     <= next_tx;
      ptr    <= next_ptr;
      blk    <= next_blk;
      dir    <= next_dir;
      mack   <= next_mack;
      sda_oe <= next_sda_oe;
    end
  end

  assign sda_out              = 1'b0;
  assign io_rail_enable_out   = rail[irec_pkg::IO_RAIL_BIT]; // [R11]
  assign main_rail_enable_out = rail[irec_pkg::MAIN_RAIL_BIT]; // [R12]

  property p_ctrl_mismatch;
    @(posedge clk) disable iff (!rstn)
    (state == irec_pkg::ST_RX && phase == irec_pkg::PH_CTRL && byte_end &&
     !start && !stop && rx[7:4] != code) |=> state == irec_pkg::ST_IDLE;
  endproperty
  a_ctrl_mismatch: assert property (p_ctrl_mismatch) // [R1]
    else $error("control code mismatch not ignored");

  property p_ack_drive;
    @(posedge clk) disable iff (!rstn)
    (state == irec_pkg::ST_ACK) |-> sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) // [R4]
    else $error("acknowledge not driven low");

  property p_word_ptr;
    @(posedge clk) disable iff (!rstn)
    (state == irec_pkg::ST_RX && phase == irec_pkg::PH_WORD && byte_end &&
     !start && !stop) |=> ptr == {$past(blk), $past(rx)};
  endproperty
  a_word_ptr: assert property (p_word_ptr) // [R2]
    else $error("pointer not loaded from block and word");

  property p_rail_commit;
    @(posedge clk) disable iff (!rstn)
    (wr.en && wr.addr == irec_pkg::RAIL_BYTE && !lock.wr_all) |=>
      io_rail_enable_out == $past(wr.data[5]) &&
      main_rail_enable_out == $past(wr.data[6]);
  endproperty
  a_rail_commit: assert property (p_rail_commit) // [R7]
    else $error("rail byte write not applied at acknowledge");

  property p_data_write;
    @(posedge clk) disable iff (!rstn)
    (state == irec_pkg::ST_RX && phase == irec_pkg::PH_DATA && byte_end &&
     !start && !stop) |-> wr.en ##1 state == irec_pkg::ST_ACK;
  endproperty
  a_data_write: assert property (p_data_write) // [R6]
    else $error("data byte not written and acknowledged");

  property p_restart_keeps_ptr;
    @(posedge clk) disable iff (!rstn)
    start |=> ptr == $past(ptr) && state == irec_pkg::ST_RX &&
              phase == irec_pkg::PH_CTRL;
  endproperty
  a_restart_keeps_ptr: assert property (p_restart_keeps_ptr) // [R8]
    else $error("repeated start disturbed the pointer");

  property p_read_load;
    @(posedge clk) disable iff (!rstn)
    (state == irec_pkg::ST_ACK && phase == irec_pkg::PH_CTRL && dir &&
     scl_fall && !start && !stop) |=>
      state == irec_pkg::ST_TX && tx == $past(rd_data) &&
      ptr == $past(ptr) + 11'd1;
  endproperty
  a_read_load: assert property (p_read_load) // [R9]
    else $error("read byte not loaded or pointer not advanced");

  property p_addr_match;
    @(posedge clk) disable iff (!rstn)
    (state == irec_pkg::ST_RX && phase == irec_pkg::PH_CTRL && byte_end &&
     !start && !stop && rx[7:1] == 7'h30 && code == 4'h6) |=>
      state == irec_pkg::ST_ACK ##1 sda_oe;
  endproperty
  a_addr_match: assert property (p_addr_match) // [R10]
    else $error("target address not answered");

  property p_read_lock;
    @(posedge clk) disable iff (!rstn)
    (lock.rd_low && irec_pkg::locked_low(ptr)) |->
      rd_data == irec_pkg::LOCKED_RD;
  endproperty
  a_read_lock: assert property (p_read_lock) // [R14]
    else $error("locked byte was readable");

  property p_tx_release;
    @(posedge clk) disable iff (!rstn)
    (state == irec_pkg::ST_TX && byte_end && !start && !stop) |=>
      state == irec_pkg::ST_MACK && !sda_oe;
  endproperty
  a_tx_release: assert property (p_tx_release) // [R15]
    else $error("data line not released after eight bits");

  c_rail_write: cover property (@(posedge clk) disable iff (!rstn)
    wr.en && wr.addr == irec_pkg::RAIL_BYTE);
  c_read_byte: cover property (@(posedge clk) disable iff (!rstn)
    state == irec_pkg::ST_TX ##[1:1000] state == irec_pkg::ST_MACK);
  c_restart: cover property (@(posedge clk) disable iff (!rstn)
    start && state == irec_pkg::ST_RX && phase == irec_pkg::PH_DATA);
  c_reject: cover property (@(posedge clk) disable iff (!rstn)
    state == irec_pkg::ST_RX && phase == irec_pkg::PH_CTRL && byte_end &&
    rx[7:4] != code);

endmodule : irec_target

// >>> dv/irec_master.sv
/*
  Bus master model: start, stop, bytes and acknowledge bits on the link.
  Assumes a pull-up on the data wire and clk for its 20 ns quarters.
*/
`timescale 1ns/10ps
module irec_master (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_m
);
  // Quarter of the 80 ns link period in clk cycles
  localparam int Q = 2;

  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic wait_q(input int n);
    repeat (n * Q) @(negedge clk);
  endtask : wait_q

  // Doubles as repeated start; clock stands high between frames
  task automatic start;
    sda_m = 1'b1;
    wait_q(1);
    scl = 1'b1;
    wait_q(2);
    sda_m = 1'b0;  // Data falls while clock high
    wait_q(2);
    scl = 1'b0;
    wait_q(1);
  endtask : start

  task automatic stop;
    sda_m = 1'b0;
    wait_q(1);
    scl = 1'b1;
    wait_q(2);
    sda_m = 1'b1;  // Data rises while clock high
    wait_q(2);
  endtask : stop

  // Data moves mid-low so it never changes near a clock edge
  task automatic xfer_bit(input logic b, output logic r);
    sda_m = b;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    r = sda_wire;
    wait_q(1);
    scl = 1'b0;
    wait_q(1);
  endtask : xfer_bit

  task automatic tx_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);  // MSB first
    xfer_bit(1'b1, nack);  // Ninth clock carries the answer
  endtask : tx_byte

  task automatic rx_byte(input logic ack_n, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
    xfer_bit(ack_n, r);
  endtask : rx_byte
endmodule : irec_master

// >>> dv/irec_target_bench.sv
/*
  Self-checking bench for the rail enable target port with a reference
  model of the bytes, pointer and code. Assumes irec_master on the link.
*/
`timescale 1ns/10ps
module irec_target_bench;
  logic                 clk;
  logic                 rstn;
  logic                 scl;
  logic                 sda_m;
  logic                 sda_out;
  logic                 sda_oe;
  logic                 sda_wire;
  logic                 io_rail;
  logic                 main_rail;
  irec_pkg::irec_lock_t lock;
  logic [7:0]           ref_mem [0:2047];
  logic [3:0]           ref_code;
  logic [10:0]          ref_ptr;
  int                   fails;
  int                   comparisons;
  int                   seed;
  logic [7:0]           rd;
  logic [7:0]           d;
  logic                 nack;

  // Open drain wire: any party pulling low wins over the pull-up
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & sda_m;

  irec_target u_irec_target (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .lock(lock),
    .io_rail_enable_out(io_rail), .main_rail_enable_out(main_rail)
  );
  irec_master u_irec_master (
    .clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_m(sda_m)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    // An unknown expectation means the scenario read unwritten storage
    if (seen !== exp || $isunknown(exp)) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic do_reset;
    @(negedge clk);
    rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    ref_mem[11'h0F4] = 8'h00;
    ref_mem[11'h0E9] = 8'h06;
    ref_code = 4'h6;
    repeat (4) @(negedge clk);
    check("oe", {7'h00, sda_oe}, 8'h00);
    check("rails", {6'h00, main_rail, io_rail}, 8'h00);  // Zero
  endtask : do_reset

  function automatic logic [7:0] ctrl(input logic [10:0] a, input logic rw);
    return {ref_code, a[10:8], rw};  // Code, block, direction
  endfunction : ctrl

  task automatic send(input logic [7:0] b, input logic exp_nack);
    u_irec_master.tx_byte(b, nack);
    check("ack", {7'h00, nack}, {7'h00, exp_nack});  // Answer
  endtask : send

  function automatic logic [7:0] expect_rd(input logic [10:0] a);
    return (lock.rd_low && a < 11'h0C0) ? 8'hFF : ref_mem[a];
  endfunction : expect_rd

  task automatic write_byte(input logic [10:0] a, input logic [7:0] v);
    u_irec_master.start();
    send(ctrl(a, 1'b0), 1'b0);
    send(a[7:0], 1'b0);  // Word address
    send(v, 1'b0);
    if (!lock.wr_all && !(lock.wr_low && a < 11'h0C0)) begin
      ref_mem[a] = v;
      if (a == 11'h0E9) ref_code = v[3:0];
    end
    ref_ptr = a + 11'h001;
    // Looked at before the stop: the data acknowledge already committed
    check("io", {7'h00, io_rail}, {7'h00, ref_mem[11'h0F4][5]});
    check("main", {7'h00, main_rail}, {7'h00, ref_mem[11'h0F4][6]});
    u_irec_master.stop();
  endtask : write_byte

  task automatic read_rand(input logic [10:0] a);
    u_irec_master.start();
    send(ctrl(a, 1'b0), 1'b0);
    send(a[7:0], 1'b0);
    u_irec_master.start();  // Repeated start drops the write
    send(ctrl(a, 1'b1), 1'b0);  // Read control acknowledged
    u_irec_master.rx_byte(1'b1, rd);
    u_irec_master.stop();
    check("rand", rd, expect_rd(a));  // Addressed byte
    ref_ptr = a + 11'h001;
  endtask : read_rand

  // Master acknowledges every byte but the last, so n > 1 walks the pointer
  task automatic read_cur(input int n);
    u_irec_master.start();
    send(ctrl(ref_ptr, 1'b1), 1'b0);
    for (int k = 0; k < n; k++) begin
      u_irec_master.rx_byte(k == n - 1, rd);
      check("cur", rd, expect_rd(ref_ptr));  // Pointer byte
      ref_ptr = ref_ptr + 11'h001;
    end
    u_irec_master.stop();
  endtask : read_cur

  task automatic code_scan;
    for (int c = 0; c < 16; c++) begin
      u_irec_master.start();
      send({c[3:0], 4'h0}, c[3:0] !== ref_code);  // Code match
      u_irec_master.stop();
    end
  endtask : code_scan

  initial begin
    rstn = 1'b0;
    lock = '0;
    seed = 32'h5349;
    fails = 0;
    comparisons = 0;
    do_reset();
    code_scan();
    $display("test reset_and_codes done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      d[6:5] = i[1:0];
      write_byte(11'h0F4, d);  // Every rail pairing
      read_rand(11'h0F4);
    end
    $display("test rails done");
    write_byte(11'h310, 8'($random(seed)));
    write_byte(11'h311, 8'($random(seed)));
    write_byte(11'h010, 8'($random(seed)));
    read_rand(11'h310);
    read_cur(1);
    read_rand(11'h010);
    $display("test block_and_pointer done");
    lock = '{rd_low: 1'b1, wr_low: 1'b0, wr_all: 1'b0};
    read_rand(11'h010);
    read_rand(11'h310);
    lock = '{rd_low: 1'b0, wr_low: 1'b1, wr_all: 1'b0};
    write_byte(11'h010, ~ref_mem[11'h010]);
    write_byte(11'h311, 8'($random(seed)));
    read_rand(11'h010);
    write_byte(11'h30F, 8'($random(seed)));
    read_cur(2);
    lock = '{rd_low: 1'b0, wr_low: 1'b0, wr_all: 1'b1};
    write_byte(11'h0F4, ~ref_mem[11'h0F4]);
    read_rand(11'h0F4);
    lock = '0;
    $display("test locks done");
    write_byte(11'h0E9, 8'h07);
    code_scan();
    write_byte(11'h0E9, 8'h06);
    write_byte(11'h0F4, 8'h60);
    do_reset();
    code_scan();
    $display("test code_and_reset done");
    results();
  end

  // Cuts a hang short at 90000 cycles, far beyond the length of a normal run
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    results();
  end
endmodule : irec_target_bench
